// ---- src/odsc_regs.svh ----
`ifndef ODSC_REGS_SVH
`define ODSC_REGS_SVH

// Shape of the 16-bit serial command word.
`define ODSC_WORD_W 16
`define ODSC_ADDR_MSB 13
`define ODSC_ADDR_LSB 11
`define ODSC_CTRL_MSB 10
`define ODSC_CTRL_LSB 8
`define ODSC_DATA_MSB 7
`define ODSC_DATA_LSB 0
// Bit of the address field that selects the serial output phase.
`define ODSC_PHASE_BIT 2

// Control field encodings.
`define ODSC_CMD_NO_OP 3'h0
`define ODSC_CMD_CLEAR 3'h1
`define ODSC_CMD_SHUTDOWN 3'h2
`define ODSC_CMD_SET_PHASE 3'h3
`define ODSC_CMD_LOAD_ALL 3'h4
`define ODSC_CMD_LOAD_INPUT 3'h5
`define ODSC_CMD_LOAD_BOTH 3'h6
`define ODSC_CMD_UPDATE 3'h7

// Channel count, code width, reset values and the half-scale code.
`define ODSC_CHANNELS 8
`define ODSC_CODE_W 8
`define ODSC_CODE_RST 8'h00
`define ODSC_EN_RST 8'hFF
`define ODSC_HALF_CODE 8'h80

// Serial output lag in whole clocks for the rising-edge phase.
`define ODSC_LAG_RISE 16

`endif

// ---- src/odsc_pkg.sv ----
package odsc_pkg;
  // Serial output phase: change on falling or on rising clock edge.
  typedef enum logic {odsc_ph_fall, odsc_ph_rise} odsc_phase_t;
endpackage

// ---- src/odsc_shifter.sv ----
`timescale 1ns/1ps
`include "odsc_regs.svh"

// Link-side shift register; runs only on the serial clock.
module odsc_shifter (
  // Link clock from the serial pins, and reset taken from the core domain.
  input wire logic sclk,
  input wire logic link_rst,
  // Serial pins.
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Phase request from the core and the captured word.
  input wire logic phase_rise,
  output logic [`ODSC_WORD_W-1:0] word
);

  // Phase request synchroniser; only the second stage is used.
  logic ph_s1_q;
  logic ph_s2_q;
  // Shift register and the half-cycle delayed copy of its top bit.
  logic [`ODSC_WORD_W-1:0] sr_q;
  logic fall_q;

  // The phase only changes between frames, so two edges of lag is harmless.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      ph_s1_q <= 1'b0;
      ph_s2_q <= 1'b0;
    end else begin
      ph_s1_q <= phase_rise;
      ph_s2_q <= ph_s1_q;
    end
  end

  // Data shifts in on rising edges while the frame is open.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      sr_q <= `ODSC_WORD_W'(0);
    end else if (!cs_n) begin
      sr_q <= {sr_q[`ODSC_WORD_W-2:0], din};
    end
  end

  // Falling-edge copy gives the extra half clock of lag.
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      fall_q <= 1'b0;
    end else if (!cs_n) begin
      fall_q <= sr_q[`ODSC_WORD_W-1];
    end
  end

  // Output select between the two phases; both sources are flops.
  assign dout = ph_s2_q ? sr_q[`ODSC_WORD_W-1] : fall_q;
  assign word = sr_q;

  // Count of consecutive shifting edges, for the lag check and the long-frame cover.
  logic [4:0] run_q;
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      run_q <= 5'h0;
    end else if (cs_n) begin
      run_q <= 5'h0;
    end else if (run_q != 5'h1F) begin
      run_q <= run_q + 5'h1;
    end
  end

  property p_dout_lag;
    @(posedge sclk) disable iff (link_rst)
      (!cs_n && run_q >= 5'h11) |-> dout == $past(din, `ODSC_LAG_RISE);
  endproperty
  a_dout_lag: assert property (p_dout_lag)
    else $error("Serial output does not lag input by sixteen clocks.");

  c_long_frame: cover property (@(posedge sclk) run_q == 5'h14);

endmodule // odsc_shifter

// ---- src/odsc_chain_port.sv ----
`timescale 1ns/1ps
`include "odsc_regs.svh"

module odsc_chain_port #(
  parameter int REF_W = 16
) (
  // Core clock and synchronous reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial link; the serial clock is its own domain.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Hardware load strobe, active low and level sensitive.
  input wire logic load_converters_strobe_n,
  // Reference level, in the same scale as the channel levels.
  input wire logic [REF_W-1:0] ref_level,
  // Converter state.
  output logic [`ODSC_CHANNELS*`ODSC_CODE_W-1:0] channel_code_value,
  output logic [`ODSC_CHANNELS*REF_W-1:0] channel_level,
  output logic [`ODSC_CHANNELS-1:0] buffer_enable,
  output logic phase_rise,
  output logic cmd_done
);

  // Level for code n is n * ref / 256, truncated.
  function automatic logic [REF_W-1:0] code_to_level(
    input logic [`ODSC_CODE_W-1:0] code,
    input logic [REF_W-1:0] ref_in
  );
    logic [REF_W+`ODSC_CODE_W-1:0] prod;
    prod = (REF_W+`ODSC_CODE_W)'(code) * (REF_W+`ODSC_CODE_W)'(ref_in);
    return prod[REF_W+`ODSC_CODE_W-1:`ODSC_CODE_W];
  endfunction

  // Reset for the link flops, registered so it is glitch free.
  logic link_rst_q;
  // Chip select synchroniser plus an edge history stage.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  // Load strobe synchroniser.
  logic ld_s1_q;
  logic ld_s2_q;
  // Reference synchroniser; the reference is quasi-static.
  logic [REF_W-1:0] ref_s1_q;
  logic [REF_W-1:0] ref_s2_q;
  // Word held by the link shifter.
  logic [`ODSC_WORD_W-1:0] link_word;
  // Input and converter registers (one byte per channel), levels, enables, phase and done flag.
  logic [`ODSC_CHANNELS-1:0][`ODSC_CODE_W-1:0] in_q;
  logic [`ODSC_CHANNELS-1:0][`ODSC_CODE_W-1:0] in_d;
  logic [`ODSC_CHANNELS-1:0][`ODSC_CODE_W-1:0] dac_q;
  logic [`ODSC_CHANNELS-1:0][`ODSC_CODE_W-1:0] dac_d;
  logic [`ODSC_CHANNELS-1:0][REF_W-1:0] lvl_q;
  logic [`ODSC_CHANNELS-1:0] en_q;
  logic [`ODSC_CHANNELS-1:0] en_d;
  odsc_pkg::odsc_phase_t ph_q;
  odsc_pkg::odsc_phase_t ph_d;
  logic done_q;

  // The link shifter reports the word and drives the serial output.
  odsc_shifter u_shifter (
    .sclk(sclk),
    .link_rst(link_rst_q),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .phase_rise(ph_q == odsc_pkg::odsc_ph_rise),
    .word(link_word)
  );

  // Synchronisers; first stages are read only by their second stages.
  always_ff @(posedge core_clk) begin
    link_rst_q <= !reset_n;
    cs_s1_q <= cs_n;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    ld_s1_q <= load_converters_strobe_n;
    ld_s2_q <= ld_s1_q;
    ref_s1_q <= ref_level;
    ref_s2_q <= ref_s1_q;
  end

  // Rising chip select closes the frame; the word is frozen by then
  // because the shifter only moves while chip select is low.
  wire frame_end = cs_s2_q && !cs_s3_q && reset_n;
  wire load_strobe_active = !ld_s2_q;
  wire [2:0] cmd = link_word[`ODSC_CTRL_MSB:`ODSC_CTRL_LSB];
  wire [2:0] addr = link_word[`ODSC_ADDR_MSB:`ODSC_ADDR_LSB];
  wire [`ODSC_CODE_W-1:0] data = link_word[`ODSC_DATA_MSB:`ODSC_DATA_LSB];
  wire no_operation_cmd = frame_end && cmd == `ODSC_CMD_NO_OP;

  // Next state of the register bank for the command just closed.
  always_comb begin
    in_d = in_q;
    dac_d = dac_q;
    en_d = en_q;
    ph_d = ph_q;
    if (frame_end) begin
      case (cmd)
        // Pass-through only: nothing changes here.
        `ODSC_CMD_NO_OP: begin
          in_d = in_q;
        end
        // Zero the input and converter registers and wake the buffers.
        `ODSC_CMD_CLEAR: begin
          in_d = '0;
          dac_d = '0;
          en_d = `ODSC_EN_RST;
        end
        // A zero data bit disables that channel's buffer.
        `ODSC_CMD_SHUTDOWN: begin
          en_d = data;
        end
        // Phase select also acts as a software update.
        `ODSC_CMD_SET_PHASE: begin
          ph_d = addr[`ODSC_PHASE_BIT] ? odsc_pkg::odsc_ph_rise
                                       : odsc_pkg::odsc_ph_fall;
          dac_d = in_q;
        end
        // Every converter gets the same code.
        `ODSC_CMD_LOAD_ALL: begin
          dac_d = {`ODSC_CHANNELS{data}};
          en_d = `ODSC_EN_RST;
        end
        // Preload one input register only.
        `ODSC_CMD_LOAD_INPUT: begin
          in_d[addr] = data;
        end
        // Load one input and its converter register.
        `ODSC_CMD_LOAD_BOTH: begin
          in_d[addr] = data;
          dac_d[addr] = data;
          en_d = `ODSC_EN_RST;
        end
        // Software update of all converters.
        `ODSC_CMD_UPDATE: begin
          dac_d = in_q;
        end
        default: begin
          in_d = in_q;
        end
      endcase
    end
    // A low hardware strobe makes the converter registers transparent.
    if (load_strobe_active) begin
      dac_d = in_d;
    end
  end

  // Register bank; all channels move on the same edge.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      in_q <= '0;
      dac_q <= '0;
      en_q <= `ODSC_EN_RST;
      ph_q <= odsc_pkg::odsc_ph_fall;
      done_q <= 1'b0;
    end else begin
      in_q <= in_d;
      dac_q <= dac_d;
      en_q <= en_d;
      ph_q <= ph_d;
      done_q <= frame_end;
    end
  end

  // Levels are registered so the product is off the output path.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lvl_q <= '0;
    end else begin
      for (int i = 0; i < `ODSC_CHANNELS; i++) begin
        lvl_q[i] <= code_to_level(dac_q[i], ref_s2_q);
      end
    end
  end

  assign channel_code_value = dac_q;
  assign channel_level = lvl_q;
  assign buffer_enable = en_q;
  assign phase_rise = (ph_q == odsc_pkg::odsc_ph_rise);
  assign cmd_done = done_q;

  property p_no_op_keeps_regs;
    @(posedge core_clk) disable iff (!reset_n)
      (no_operation_cmd && !load_strobe_active)
        |=> $stable(in_q) && $stable(dac_q);
  endproperty
  a_no_op_keeps_regs: assert property (p_no_op_keeps_regs)
    else $error("No-operation changed an input or converter register.");

  property p_no_op_keeps_mode;
    @(posedge core_clk) disable iff (!reset_n)
      no_operation_cmd |=> $stable(en_q) && $stable(ph_q) && cmd_done;
  endproperty
  a_no_op_keeps_mode: assert property (p_no_op_keeps_mode)
    else $error("No-operation changed shutdown or phase state.");

  property p_codes_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (!frame_end && !load_strobe_active) |=> $stable(dac_q);
  endproperty
  a_codes_hold: assert property (p_codes_hold)
    else $error("Converter register moved outside a frame end.");

  property p_load_input;
    @(posedge core_clk) disable iff (!reset_n)
      (frame_end && cmd == `ODSC_CMD_LOAD_INPUT)
        |=> in_q[$past(addr)] == $past(data);
  endproperty
  a_load_input: assert property (p_load_input)
    else $error("Selected input register not loaded at frame end.");

  property p_phase_fall_cmd;
    @(posedge core_clk) disable iff (!reset_n)
      (frame_end && cmd == `ODSC_CMD_SET_PHASE && !addr[`ODSC_PHASE_BIT])
        |=> !phase_rise ##1 !phase_rise;
  endproperty
  a_phase_fall_cmd: assert property (p_phase_fall_cmd)
    else $error("Falling-phase command did not select falling phase.");

  property p_phase_after_reset;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> !phase_rise;
  endproperty
  a_phase_after_reset: assert property (p_phase_after_reset)
    else $error("Serial output phase is not falling after reset.");

  property p_half_code_level;
    @(posedge core_clk) disable iff (!reset_n)
      (dac_q[0] == `ODSC_HALF_CODE && $stable(dac_q[0]) && $stable(ref_s2_q))
        |-> lvl_q[0] == (ref_s2_q >> 1);
  endproperty
  a_half_code_level: assert property (p_half_code_level)
    else $error("Half code does not give half the reference.");

  c_no_op_frame: cover property (@(posedge core_clk) no_operation_cmd);
  c_phase_rise: cover property (@(posedge core_clk) $rose(phase_rise));
  c_strobe_load: cover property (@(posedge core_clk)
    load_strobe_active && frame_end && cmd == `ODSC_CMD_LOAD_INPUT);

endmodule // odsc_chain_port

// ---- dv/odsc_host_model.sv ----
`timescale 1ns/1ps

// Serial host: one frame at a time, clock parked low between frames.
module odsc_host_model (
  // Serial pins towards the device.
  output logic sclk,
  output logic cs_n,
  output logic din,
  // Returned serial data.
  input wire logic dout
);
  logic [31:0] rx_rise = 32'h0000_0000; // Samples taken before each rise.
  logic [31:0] rx_fall = 32'h0000_0000; // Samples taken before each fall.

  // Idle pins before the first frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Three plain lines, data set while the clock is low.
  // An inverted mode-two port gives this same idle-low waveform.
  // With hi set the clock parks high inside the frame (polarity and
  // phase one), so the returned data is not trusted there. The last
  // falling edge is then missing, so such frames stay one word long.
  task automatic frame(input logic [31:0] w, input int n, input logic hi);
    #1.7;
    sclk = hi;
    #1;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = w[i];
      #3;
      // Sample before the edge so the device's update cannot race it.
      rx_rise = {rx_rise[30:0], dout};
      sclk = 1'b1;
      #3;
      rx_fall = {rx_fall[30:0], dout};
    end
    sclk = hi;
    #3;
    cs_n = 1'b1;
    // A released data line must not look like it still holds its bit.
    din = ~din;
    #3;
    sclk = 1'b0;
  endtask
endmodule // odsc_host_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "odsc_regs.svh"

// Random frames checked against a model of the command set.
module tb;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    num_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); \
    end end
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic load_converters_strobe_n = 1'b1;
  logic [15:0] ref_lv = 16'h0000;
  wire sclk, cs_n, din, dout, phase_rise, cmd_done;
  wire [63:0] codes;
  wire [127:0] levels;
  wire [7:0] en;
  logic [7:0] m_in [8] = '{default: 8'h00}; // Expected input registers.
  logic [7:0] m_code [8] = '{default: 8'h00}; // Expected converter codes.
  logic [7:0] m_en = 8'hFF;
  logic m_ph = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 21444;

  odsc_chain_port #(.REF_W(16)) dut (.core_clk(core_clk),
    .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .load_converters_strobe_n(load_converters_strobe_n),
    .ref_level(ref_lv), .channel_code_value(codes), .channel_level(levels),
    .buffer_enable(en), .phase_rise(phase_rise), .cmd_done(cmd_done));
  odsc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // Core clock, 5 ns period.
  always #2.5 core_clk = ~core_clk;

  // Level as the converter should give it; truncation is intended.
  function automatic logic [15:0] lvl(input logic [7:0] c);
    logic [23:0] p;
    p = c * ref_lv;
    return p[23:8];
  endfunction

  // Expected effect of one word; a low strobe makes codes follow inputs.
  task automatic model(input logic [15:0] w, input logic s);
    case (w[10:8])
      3'h1: begin m_in = '{default: 8'h00}; m_code = m_in; m_en = 8'hFF; end
      3'h2: m_en = w[7:0];
      3'h3: begin m_ph = w[13]; m_code = m_in; end
      3'h4: begin m_code = '{default: w[7:0]}; m_en = 8'hFF; end
      3'h5: m_in[w[13:11]] = w[7:0];
      3'h6: begin m_in[w[13:11]] = w[7:0]; m_code[w[13:11]] = w[7:0];
        m_en = 8'hFF; end
      3'h7: m_code = m_in;
      default: ;
    endcase
    if (!s) m_code = m_in;
  endtask

  // Wait for the frame to execute, then compare every parallel output.
  task automatic settle();
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(cmd_done, 1'b1)
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      `CHK(codes[8*i +: 8], m_code[i])
      `CHK(levels[16*i +: 16], lvl(m_code[i]))
    end
    `CHK(en, m_en)
    `CHK(phase_rise, m_ph)
  endtask

  task automatic test_done();
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence.
  initial begin
    logic [15:0] w;
    logic [15:0] r;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK(phase_rise, 1'b0)
    `CHK(codes, 64'h0000_0000_0000_0000)
    `CHK(levels, 128'h0)
    `CHK(en, 8'hFF)
    repeat (4) @(posedge core_clk);
    // Every command once, then half and full scale, then random words.
    for (int i = 0; i < 30; i++) begin
      w = 16'($random(seed));
      r = 16'($random(seed));
      if (i < 8) w[10:8] = i[2:0];
      if (i == 8) w = 16'h0480;
      if (i == 9) w = 16'h36FF;
      if (i < 10) r[0] = 1'b1;
      @(posedge core_clk);
      load_converters_strobe_n <= r[0];
      ref_lv <= r;
      model(w, r[0]);
      host.frame({16'h0000, w}, 16, i >= 10 && r[1]);
      settle();
    end
    // Chain of two: far word passes through, this device sees a no-op.
    @(posedge core_clk);
    load_converters_strobe_n <= 1'b1;
    for (int p = 1; p >= 0; p--) begin
      w = {2'b00, p[0], 2'b00, 3'h3, 8'h00};
      model(w, 1'b1);
      host.frame({16'h0000, w}, 16, 1'b0);
      settle();
      w = 16'($random(seed));
      r = 16'($random(seed));
      r[10:8] = 3'h0;
      model(r, 1'b1);
      host.frame({w, r}, 32, 1'b0);
      settle();
      if (p == 1) `CHK(host.rx_fall[16:1], w)
      else `CHK(host.rx_rise[15:0], w)
    end
    test_done();
  end

  // Watchdog well beyond the expected run time.
  initial begin
    #150000;
    num_errors++;
    test_done();
  end
endmodule // tb
